// ---- dcr_pkg.sv ----
// constants shared by both ends of the codec control register link
// assumes one 40 MHz clock and an active-low asynchronous reset
package dcr_pkg;
  // ---------------------------------------------------------------
  // sizes and timing
  // ---------------------------------------------------------------
  localparam int CODECS = 2;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SELF_TEST_DELAY_NS = 1000000;
  localparam int SELF_TEST_CYCLES = (SELF_TEST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ---------------------------------------------------------------
  // device register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_MIX0 = 4'h2;
  localparam logic [3:0] ADDR_MIX1 = 4'h3;
  localparam logic [3:0] ADDR_OSC0 = 4'h4;
  localparam logic [3:0] ADDR_OSC1 = 4'h5;
  localparam logic [3:0] ADDR_LSD0 = 4'h6;
  localparam logic [3:0] ADDR_LSD1 = 4'h7;
  localparam logic [3:0] ADDR_CTL4 = 4'h8;
  localparam logic [3:0] ADDR_CTL5 = 4'h9;
  localparam logic [3:0] ADDR_RSV6 = 4'hA;
  localparam logic [3:0] ADDR_RSV7 = 4'hB;
  localparam logic [3:0] ADDR_SYNC = 4'hF;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int MIX_HPF_BIT = 6;
  localparam int MIX_GAIN_LSB = 4;
  localparam int MIX_RX_LSB = 2;
  localparam int MIX_TX_LSB = 0;
  localparam int OSC_SEL_BIT = 6;
  localparam int CTL4_SWRST_BIT = 4;
  localparam int CTL4_TSRC_BIT = 2;
  localparam int CTL4_SYSDIV_LSB = 0;
  localparam int CTL5_CHECK_LSB = 4;
  localparam int CTL5_TRSVD_LSB = 3;
  localparam int CTL5_ECHO_BIT = 2;
  localparam int CTL5_TMODE_LSB = 0;
  // ---------------------------------------------------------------
  // reset and fixed values
  // ---------------------------------------------------------------
  localparam logic [6:0] RST_MIX = 7'h00;
  localparam logic [5:0] RST_OSDIV = 6'h10;
  localparam logic [6:0] RST_SMPDIV = 7'h33;
  localparam logic [6:0] SMPDIV_MIN = 7'h33;
  localparam logic [1:0] RST_SYSDIV = 2'h2;
  localparam logic [7:0] SYNC_LOCKED_VAL = 8'h55;
  localparam logic [7:0] SYNC_UNLOCKED_VAL = 8'h00;
  localparam logic [6:0] SYSCLK_OS_RATIO = 7'h08;
  // ---------------------------------------------------------------
  // host command port offsets and bits
  // ---------------------------------------------------------------
  localparam logic [2:0] HADDR_TARGET = 3'h0;
  localparam logic [2:0] HADDR_WDATA = 3'h1;
  localparam logic [2:0] HADDR_CMD = 3'h2;
  localparam logic [2:0] HADDR_RESULT = 3'h3;
  localparam logic [2:0] HADDR_STATUS = 3'h4;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_READ_BIT = 1;
endpackage

// ---- dcr_link_if.sv ----
// register access link between the host engine and the codec register bank
// both ends run on the same sys_clk; strobes are one cycle long
interface dcr_link_if;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic rvalid;
  modport dev (input addr, input wdata, input wr, input rd, output rdata, output rvalid);
  modport host (output addr, output wdata, output wr, output rd, input rdata, input rvalid);
endinterface

// ---- dcr_device.sv ----
// codec control and status register bank, device end of the link
// assumes host strobes are one cycle, synchronous to sys_clk, never both at once
//
// Chosen here: the plain strobed port.
module dcr_device #(
  parameter int unsigned SELF_TEST_CYCLES = dcr_pkg::SELF_TEST_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  dcr_link_if.dev link,
  input wire logic single_dual_port_select_pin,
  input wire logic [2:0] self_test_fail,
  input wire logic framing_lost,
  output logic [dcr_pkg::CODECS-1:0] voice_highpass_enable,
  output logic [dcr_pkg::CODECS-1:0][1:0] input_gain,
  output logic [dcr_pkg::CODECS-1:0][1:0] mixer_receive_level,
  output logic [dcr_pkg::CODECS-1:0][1:0] mixer_transmit_level,
  output logic [dcr_pkg::CODECS-1:0][5:0] oversample_clock_divider,
  output logic [dcr_pkg::CODECS-1:0] master_clock_source_select,
  output logic [dcr_pkg::CODECS-1:0][6:0] sampling_clock_divider,
  output logic [1:0] system_clock_divider,
  output logic serial_timing_source,
  output logic single_port_mode,
  output logic sample_echo_enable,
  output logic [1:0] test_mode,
  output logic speaker_power_down,
  output logic self_check_done,
  output logic framing_locked
);
  import dcr_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [CODECS-1:0][6:0] mix, next_mix;
  logic [CODECS-1:0] osc_sel, next_osc_sel;
  logic [CODECS-1:0][5:0] osc_div, next_osc_div;
  logic [CODECS-1:0][6:0] ls_div, next_ls_div;
  logic ts_src, next_ts_src;
  logic [1:0] sysclk_div, next_sysclk_div;
  logic echo, next_echo;
  logic [1:0] tmode, next_tmode;
  logic [1:0] trsvd, next_trsvd;
  logic swrst, next_swrst;
  logic [2:0] self_check, next_self_check;
  logic [31:0] st_cnt, next_st_cnt;
  logic st_done, next_st_done;
  logic locked, next_locked;
  logic one_port, next_one_port;
  logic tsrc_eff, next_tsrc_eff;
  logic spk_pd, next_spk_pd;
  logic [7:0] rdata, next_rdata;
  logic rvalid, next_rvalid;

  // odd offsets belong to codec one
  function automatic int codec_of(input logic [3:0] a);
    return int'(a[0]);
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_mix = mix;
    next_osc_sel = osc_sel;
    next_osc_div = osc_div;
    next_ls_div = ls_div;
    next_ts_src = ts_src;
    next_sysclk_div = sysclk_div;
    next_echo = echo;
    next_tmode = tmode;
    next_trsvd = trsvd;
    next_swrst = 1'b0;
    next_self_check = self_check;
    next_st_cnt = st_cnt;
    next_st_done = st_done;
    next_locked = locked;
    next_one_port = single_dual_port_select_pin;
    next_rvalid = link.rd;
    next_rdata = 8'h00;
    if (framing_lost)
    begin
      next_locked = 1'b0;
    end
    // set wins over a loss of framing in the same cycle
    if ((link.wr || link.rd) && link.addr == ADDR_SYNC)
    begin
      next_locked = 1'b1;
    end
    if (link.wr)
    begin
      // bit 7 of wdata is never stored
      case (link.addr)
        ADDR_MIX0, ADDR_MIX1:
        begin
          next_mix[codec_of(link.addr)] = link.wdata[6:0];
        end
        ADDR_OSC0, ADDR_OSC1:
        begin
          next_osc_sel[codec_of(link.addr)] = link.wdata[OSC_SEL_BIT];
          next_osc_div[codec_of(link.addr)] = link.wdata[5:0];
        end
        ADDR_LSD0, ADDR_LSD1:
        begin
          if (link.wdata[6:0] < SMPDIV_MIN)
          begin
            next_ls_div[codec_of(link.addr)] = SMPDIV_MIN;
          end
          else
          begin
            next_ls_div[codec_of(link.addr)] = link.wdata[6:0];
          end
        end
        ADDR_CTL4:
        begin
          next_swrst = link.wdata[CTL4_SWRST_BIT];
          next_ts_src = link.wdata[CTL4_TSRC_BIT];
          next_sysclk_div = link.wdata[CTL4_SYSDIV_LSB +: 2];
        end
        ADDR_CTL5:
        begin
          next_trsvd = link.wdata[CTL5_TRSVD_LSB +: 2];
          next_echo = link.wdata[CTL5_ECHO_BIT];
          next_tmode = link.wdata[CTL5_TMODE_LSB +: 2];
        end
        default:
        begin
          next_swrst = 1'b0;
        end
      endcase
    end
    if (link.rd)
    begin
      // write-only fields read back as zero
      case (link.addr)
        ADDR_MIX0, ADDR_MIX1: next_rdata = {1'b0, mix[codec_of(link.addr)]};
        ADDR_OSC0, ADDR_OSC1: next_rdata = {2'b00, osc_div[codec_of(link.addr)]};
        ADDR_LSD0, ADDR_LSD1: next_rdata = {1'b0, ls_div[codec_of(link.addr)]};
        ADDR_CTL5: next_rdata = {1'b0, self_check, 4'h0};
        ADDR_SYNC: next_rdata = locked ? SYNC_LOCKED_VAL : SYNC_UNLOCKED_VAL;
        default: next_rdata = 8'h00;
      endcase
    end
    if (!st_done)
    begin
      if (st_cnt == SELF_TEST_CYCLES - 1)
      begin
        next_st_done = 1'b1;
        next_self_check = self_test_fail;
      end
      else
      begin
        next_st_cnt = st_cnt + 32'd1;
      end
    end
    // software reset: one cycle after the write everything returns to reset
    if (swrst)
    begin
      next_mix = '{default: RST_MIX};
      next_osc_sel = '0;
      next_osc_div = '{default: RST_OSDIV};
      next_ls_div = '{default: RST_SMPDIV};
      next_ts_src = 1'b0;
      next_sysclk_div = RST_SYSDIV;
      next_echo = 1'b0;
      next_tmode = 2'b00;
      next_trsvd = 2'b00;
      next_swrst = 1'b0;
      next_self_check = 3'b000;
      next_st_cnt = 32'd0;
      next_st_done = 1'b0;
      next_locked = 1'b0;
      next_rdata = 8'h00;
      next_rvalid = 1'b0;
    end
    next_tsrc_eff = next_one_port & next_ts_src;
    next_spk_pd = 1'b1;
    for (int c = 0; c < CODECS; c++)
    begin
      if (next_mix[c][MIX_RX_LSB +: 2] != 2'b00 || next_mix[c][MIX_TX_LSB +: 2] != 2'b00)
      begin
        next_spk_pd = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mix <= '{default: RST_MIX};
      osc_sel <= '0;
      osc_div <= '{default: RST_OSDIV};
      ls_div <= '{default: RST_SMPDIV};
      ts_src <= 1'b0;
      sysclk_div <= RST_SYSDIV;
      echo <= 1'b0;
      tmode <= 2'b00;
      trsvd <= 2'b00;
      swrst <= 1'b0;
      self_check <= 3'b000;
      st_cnt <= 32'd0;
      st_done <= 1'b0;
      locked <= 1'b0;
      one_port <= 1'b0;
      tsrc_eff <= 1'b0;
      spk_pd <= 1'b1;
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end
    else
    begin
      mix <= next_mix;
      osc_sel <= next_osc_sel;
      osc_div <= next_osc_div;
      ls_div <= next_ls_div;
      ts_src <= next_ts_src;
      sysclk_div <= next_sysclk_div;
      echo <= next_echo;
      tmode <= next_tmode;
      trsvd <= next_trsvd;
      swrst <= next_swrst;
      self_check <= next_self_check;
      st_cnt <= next_st_cnt;
      st_done <= next_st_done;
      locked <= next_locked;
      one_port <= next_one_port;
      tsrc_eff <= next_tsrc_eff;
      spk_pd <= next_spk_pd;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all slices of flops
  // ---------------------------------------------------------------
  generate
    for (genvar g = 0; g < CODECS; g++)
    begin : g_codec
      assign voice_highpass_enable[g] = mix[g][MIX_HPF_BIT];
      assign input_gain[g] = mix[g][MIX_GAIN_LSB +: 2];
      assign mixer_receive_level[g] = mix[g][MIX_RX_LSB +: 2];
      assign mixer_transmit_level[g] = mix[g][MIX_TX_LSB +: 2];
    end
  endgenerate
  assign oversample_clock_divider = osc_div;
  assign master_clock_source_select = osc_sel;
  assign sampling_clock_divider = ls_div;
  assign system_clock_divider = sysclk_div;
  assign serial_timing_source = tsrc_eff;
  assign single_port_mode = one_port;
  assign sample_echo_enable = echo;
  assign test_mode = tmode;
  assign speaker_power_down = spk_pd;
  assign self_check_done = st_done;
  assign framing_locked = locked;
  assign link.rdata = rdata;
  assign link.rvalid = rvalid;
endmodule

// ---- dcr_host.sv ----
// host engine: takes commands on a plain register port, drives the link
// assumes user strobes are one cycle and never both at once
module dcr_host (
  input wire logic sys_clk,
  input wire logic rstn,
  dcr_link_if.host link,
  input wire logic single_dual_port_select_pin,
  input wire logic [2:0] user_addr,
  input wire logic [7:0] user_wdata,
  input wire logic user_wr,
  input wire logic user_rd,
  output logic [7:0] user_rdata
);
  import dcr_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_STROBE, H_WAIT} dcr_hstate_t;

  dcr_hstate_t state, next_state;
  logic [3:0] tgt, next_tgt;
  logic [7:0] wval, next_wval;
  logic [7:0] result, next_result;
  logic op_rd, next_op_rd;
  logic rd_done, next_rd_done;
  logic refused, next_refused;
  logic sync_ok, next_sync_ok;
  logic [CODECS-1:0][5:0] sh_os, next_sh_os;
  logic [CODECS-1:0][6:0] sh_ls, next_sh_ls;
  logic [3:0] l_addr, next_l_addr;
  logic [7:0] l_wdata, next_l_wdata;
  logic l_wr, next_l_wr;
  logic l_rd, next_l_rd;
  logic [7:0] urd, next_urd;
  logic [7:0] wout;
  logic [5:0] os_min;

  // slowest system divider not above req that keeps sys >= 8x oversample
  function automatic logic [1:0] pick_sysdiv(input logic [1:0] req, input logic [5:0] hs);
    logic [6:0] r2 [4];
    logic [1:0] pick;
    r2 = '{7'd2, 7'd3, 7'd4, 7'd6};
    pick = 2'b00;
    for (int d = 0; d < 4; d++)
    begin
      if (d <= int'(req) && {hs, 1'b0} >= 7'(SYSCLK_OS_RATIO * r2[d]))
      begin
        pick = 2'(d);
      end
    end
    return pick;
  endfunction

  always_comb
  begin
    next_state = state;
    next_tgt = tgt;
    next_wval = wval;
    next_result = result;
    next_op_rd = op_rd;
    next_rd_done = rd_done;
    next_refused = refused;
    next_sync_ok = sync_ok;
    next_sh_os = sh_os;
    next_sh_ls = sh_ls;
    next_l_addr = l_addr;
    next_l_wdata = l_wdata;
    next_l_wr = 1'b0;
    next_l_rd = 1'b0;
    next_urd = 8'h00;
    os_min = (sh_os[0] < sh_os[1]) ? sh_os[0] : sh_os[1];
    wout = wval;
    if (tgt == ADDR_CTL4)
    begin
      // faster codec has the smaller divider product
      if (single_dual_port_select_pin)
      begin
        wout[CTL4_TSRC_BIT] = (13'(sh_os[1] * sh_ls[1]) < 13'(sh_os[0] * sh_ls[0]));
      end
      wout[CTL4_SYSDIV_LSB +: 2] = pick_sysdiv(wval[CTL4_SYSDIV_LSB +: 2], os_min);
    end
    else if (tgt == ADDR_CTL5)
    begin
      wout = {5'b00000, wval[CTL5_ECHO_BIT], 2'b00};
    end
    if (user_rd)
    begin
      case (user_addr)
        HADDR_TARGET: next_urd = {4'h0, tgt};
        HADDR_WDATA: next_urd = wval;
        HADDR_RESULT: next_urd = result;
        HADDR_STATUS: next_urd = {4'h0, sync_ok, refused, rd_done, state != H_IDLE};
        default: next_urd = 8'h00;
      endcase
      if (user_addr == HADDR_STATUS)
      begin
        next_rd_done = 1'b0;
        next_refused = 1'b0;
      end
    end
    unique case (state)
      H_IDLE:
      begin
        if (user_wr && user_addr == HADDR_TARGET)
        begin
          next_tgt = user_wdata[3:0];
        end
        if (user_wr && user_addr == HADDR_WDATA)
        begin
          next_wval = user_wdata;
        end
        if (user_wr && user_addr == HADDR_CMD)
        begin
          if (user_wdata[CMD_WRITE_BIT] && (tgt == ADDR_RSV6 || tgt == ADDR_RSV7))
          begin
            next_refused = 1'b1;
          end
          else if (user_wdata[CMD_WRITE_BIT] || user_wdata[CMD_READ_BIT])
          begin
            next_op_rd = !user_wdata[CMD_WRITE_BIT];
            next_l_addr = tgt;
            next_l_wdata = wout;
            next_l_wr = user_wdata[CMD_WRITE_BIT];
            next_l_rd = !user_wdata[CMD_WRITE_BIT];
            next_state = H_STROBE;
            if (user_wdata[CMD_WRITE_BIT])
            begin
              if (tgt == ADDR_OSC0 || tgt == ADDR_OSC1)
              begin
                next_sh_os[int'(tgt[0])] = wout[5:0];
              end
              if (tgt == ADDR_LSD0 || tgt == ADDR_LSD1)
              begin
                next_sh_ls[int'(tgt[0])] = (wout[6:0] < SMPDIV_MIN) ? SMPDIV_MIN : wout[6:0];
              end
              if (tgt == ADDR_CTL4 && wout[CTL4_SWRST_BIT])
              begin
                next_sh_os = '{default: RST_OSDIV};
                next_sh_ls = '{default: RST_SMPDIV};
                next_sync_ok = 1'b0;
              end
            end
          end
        end
      end
      H_STROBE:
      begin
        next_state = op_rd ? H_WAIT : H_IDLE;
      end
      H_WAIT:
      begin
        if (link.rvalid)
        begin
          next_result = link.rdata;
          next_rd_done = 1'b1;
          if (l_addr == ADDR_SYNC)
          begin
            next_sync_ok = (link.rdata == SYNC_LOCKED_VAL);
          end
          next_state = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= H_IDLE;
      tgt <= 4'h0;
      wval <= 8'h00;
      result <= 8'h00;
      op_rd <= 1'b0;
      rd_done <= 1'b0;
      refused <= 1'b0;
      sync_ok <= 1'b0;
      sh_os <= '{default: RST_OSDIV};
      sh_ls <= '{default: RST_SMPDIV};
      l_addr <= 4'h0;
      l_wdata <= 8'h00;
      l_wr <= 1'b0;
      l_rd <= 1'b0;
      urd <= 8'h00;
    end
    else
    begin
      state <= next_state;
      tgt <= next_tgt;
      wval <= next_wval;
      result <= next_result;
      op_rd <= next_op_rd;
      rd_done <= next_rd_done;
      refused <= next_refused;
      sync_ok <= next_sync_ok;
      sh_os <= next_sh_os;
      sh_ls <= next_sh_ls;
      l_addr <= next_l_addr;
      l_wdata <= next_l_wdata;
      l_wr <= next_l_wr;
      l_rd <= next_l_rd;
      urd <= next_urd;
    end
  end

  assign link.addr = l_addr;
  assign link.wdata = l_wdata;
  assign link.wr = l_wr;
  assign link.rd = l_rd;
  assign user_rdata = urd;
endmodule

// ---- dcr_top_note_placeholder_removed.sv ----
// spare unit: no logic lives here

// ---- dcr_link_props.sv ----
// ---------------------------------------------------------------
// checker on the register link between host engine and device
// ---------------------------------------------------------------
// assumes one sys_clk domain and the active-low asynchronous rstn
module dcr_link_props (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  import dcr_pkg::*;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  sequence s_sync_rd;
    rd && addr == ADDR_SYNC ##1 rvalid;
  endsequence
  sequence s_smpdiv_rd;
    rd && (addr == ADDR_LSD0 || addr == ADDR_LSD1);
  endsequence
  property p_read_answer;
    rd |=> rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_rvalid_cause;
    rvalid |-> $past(rd);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause) else $error("answer without read");
  property p_idle_zero;
    !rvalid |-> rdata == 8'h00;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data outside answer");
  property p_msb_zero;
    rvalid |-> !rdata[7];
  endproperty
  a_msb_zero: assert property (p_msb_zero) else $error("top bit set");
  property p_sync_value;
    s_sync_rd |-> (rdata == SYNC_LOCKED_VAL || rdata == SYNC_UNLOCKED_VAL);
  endproperty
  a_sync_value: assert property (p_sync_value) else $error("bad sync value");
  property p_smpdiv_min;
    s_smpdiv_rd |=> rvalid && rdata[6:0] >= SMPDIV_MIN;
  endproperty
  a_smpdiv_min: assert property (p_smpdiv_min) else $error("divider below minimum");
  property p_osc_sel_hidden;
    rd && (addr == ADDR_OSC0 || addr == ADDR_OSC1) |=> rdata[7:6] == 2'b00;
  endproperty
  a_osc_sel_hidden: assert property (p_osc_sel_hidden) else $error("select bit read");
  property p_ctl4_hidden;
    rd && addr == ADDR_CTL4 |=> rdata == 8'h00;
  endproperty
  a_ctl4_hidden: assert property (p_ctl4_hidden) else $error("write-only reg read");
  property p_rsv_untouched;
    !(wr && (addr == ADDR_RSV6 || addr == ADDR_RSV7));
  endproperty
  a_rsv_untouched: assert property (p_rsv_untouched) else $error("reserved write");
  property p_strobe_pulse;
    (wr |=> !wr) and !(wr && rd);
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("bad strobe");
endmodule

// ---- dual_codec_control_registers_tb.sv ----
// ---------------------------------------------------------------
// testbench: host engine and register bank joined by the link
// ---------------------------------------------------------------
// drives the host user port; short self-test count for speed
module dual_codec_control_registers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dcr_pkg::*;
  localparam int STC = 20;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic single_dual_port_select_pin = 1'b0;
  logic [2:0] self_test_fail = 3'b101;
  logic framing_lost = 1'b0;
  logic [2:0] user_addr = 3'h0;
  logic [7:0] user_wdata = 8'h00;
  logic user_wr = 1'b0;
  logic user_rd = 1'b0;
  logic [7:0] user_rdata;
  logic [1:0] voice_highpass_enable;
  logic [1:0][1:0] input_gain;
  logic [1:0][1:0] mixer_receive_level;
  logic [1:0][1:0] mixer_transmit_level;
  logic [1:0][5:0] oversample_clock_divider;
  logic [1:0] master_clock_source_select;
  logic [1:0][6:0] sampling_clock_divider;
  logic [1:0] system_clock_divider;
  logic serial_timing_source;
  logic single_port_mode;
  logic sample_echo_enable;
  logic [1:0] test_mode;
  logic speaker_power_down;
  logic self_check_done;
  logic framing_locked;
  int miscompares = 0;
  int check_count = 0;
  logic [7:0] v;
  dcr_link_if dcr_link_if_i ();
  dcr_device #(.SELF_TEST_CYCLES(STC)) dcr_device_i (
    .sys_clk(sys_clk), .rstn(rstn), .link(dcr_link_if_i),
    .single_dual_port_select_pin(single_dual_port_select_pin),
    .self_test_fail(self_test_fail), .framing_lost(framing_lost),
    .voice_highpass_enable(voice_highpass_enable), .input_gain(input_gain),
    .mixer_receive_level(mixer_receive_level), .mixer_transmit_level(mixer_transmit_level),
    .oversample_clock_divider(oversample_clock_divider),
    .master_clock_source_select(master_clock_source_select),
    .sampling_clock_divider(sampling_clock_divider), .system_clock_divider(system_clock_divider),
    .serial_timing_source(serial_timing_source), .single_port_mode(single_port_mode),
    .sample_echo_enable(sample_echo_enable), .test_mode(test_mode),
    .speaker_power_down(speaker_power_down), .self_check_done(self_check_done),
    .framing_locked(framing_locked));
  dcr_host dcr_host_i (
    .sys_clk(sys_clk), .rstn(rstn), .link(dcr_link_if_i),
    .single_dual_port_select_pin(single_dual_port_select_pin), .user_addr(user_addr),
    .user_wdata(user_wdata), .user_wr(user_wr), .user_rd(user_rd), .user_rdata(user_rdata));
  dcr_link_props dcr_link_props_i (
    .sys_clk(sys_clk), .rstn(rstn), .addr(dcr_link_if_i.addr), .wdata(dcr_link_if_i.wdata),
    .wr(dcr_link_if_i.wr), .rd(dcr_link_if_i.rd), .rdata(dcr_link_if_i.rdata),
    .rvalid(dcr_link_if_i.rvalid));
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic uw(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    user_addr <= a;
    user_wdata <= d;
    user_wr <= 1'b1;
    @(posedge sys_clk);
    user_wr <= 1'b0;
  endtask
  // data stands only in the cycle after the read strobe
  task automatic ur(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    user_addr <= a;
    user_rd <= 1'b1;
    @(posedge sys_clk);
    user_rd <= 1'b0;
    #1;
    d = user_rdata;
  endtask
  task automatic wait_idle;
    logic [7:0] s;
    for (int i = 0; i < 40; i++)
    begin
      ur(HADDR_STATUS, s);
      if (s[0] === 1'b0)
        return;
    end
    miscompares++;
    $display("BAD %0t host stuck busy", $time);
    print_verdict();
  endtask
  task automatic dw(input logic [3:0] a, input logic [7:0] d);
    uw(HADDR_TARGET, {4'h0, a});
    uw(HADDR_WDATA, d);
    uw(HADDR_CMD, 8'h01);
    wait_idle();
  endtask
  task automatic dr(input logic [3:0] a, output logic [7:0] d);
    uw(HADDR_TARGET, {4'h0, a});
    uw(HADDR_CMD, 8'h02);
    wait_idle();
    ur(HADDR_RESULT, d);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    dr(ADDR_MIX0, v);
    check(v, 8'h00);
    dr(ADDR_OSC0, v);
    check(v, 8'h10);
    dr(ADDR_LSD1, v);
    check(v, 8'h33);
    check({7'h0, speaker_power_down}, 8'h01);
    $display("reset values done");
    dw(ADDR_MIX0, 8'hFF);
    dr(ADDR_MIX0, v);
    check(v, 8'h7F);
    check({6'h0, voice_highpass_enable}, 8'h01);
    check({mixer_receive_level, mixer_transmit_level}, 8'h33);
    check({7'h0, speaker_power_down}, 8'h00);
    for (int g = 0; g < 4; g++)
    begin
      dw(ADDR_MIX1, 8'(g << 4));
      check({4'h0, input_gain}, 8'(g * 4 + 3));
    end
    dw(ADDR_MIX0, 8'h00);
    check({7'h0, speaker_power_down}, 8'h01);
    $display("mixer done");
    // requests above the oversample divider budget are lowered by the host
    for (int c = 0; c < 4; c++)
    begin
      dw(ADDR_CTL4, 8'(c));
      check({6'h0, system_clock_divider}, (c == 3) ? 8'h02 : 8'(c));
    end
    dr(ADDR_CTL4, v);
    check(v, 8'h00);
    dw(ADDR_LSD0, 8'h32);
    dr(ADDR_LSD0, v);
    check(v, 8'h33);
    dw(ADDR_LSD0, 8'h34);
    dr(ADDR_LSD0, v);
    check(v, 8'h34);
    check({1'h0, sampling_clock_divider[0]}, 8'h34);
    dw(ADDR_OSC1, 8'h48);
    dr(ADDR_OSC1, v);
    check(v, 8'h08);
    check({6'h0, master_clock_source_select}, 8'h02);
    check({2'h0, oversample_clock_divider[1]}, 8'h08);
    $display("clock fields done");
    @(posedge sys_clk);
    single_dual_port_select_pin <= 1'b1;
    dw(ADDR_CTL4, 8'h02);
    check({6'h0, system_clock_divider}, 8'h00);
    check({6'h0, single_port_mode, serial_timing_source}, 8'h03);
    @(posedge sys_clk);
    single_dual_port_select_pin <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    check({6'h0, single_port_mode, serial_timing_source}, 8'h00);
    $display("serial mode done");
    dw(ADDR_CTL5, 8'h07);
    check({5'h0, sample_echo_enable, test_mode}, 8'h04);
    dr(ADDR_CTL5, v);
    check(v, 8'h50);
    uw(HADDR_TARGET, {4'h0, ADDR_RSV6});
    uw(HADDR_CMD, 8'h01);
    ur(HADDR_STATUS, v);
    check(v & 8'h05, 8'h04);
    $display("test register done");
    dr(ADDR_SYNC, v);
    check(v, 8'h00);
    dr(ADDR_SYNC, v);
    check(v, 8'h55);
    @(posedge sys_clk);
    framing_lost <= 1'b1;
    @(posedge sys_clk);
    framing_lost <= 1'b0;
    #1;
    check({7'h0, framing_locked}, 8'h00);
    dw(ADDR_SYNC, 8'h12);
    dr(ADDR_SYNC, v);
    check(v, 8'h55);
    check({7'h0, framing_locked}, 8'h01);
    $display("sync done");
    @(posedge sys_clk);
    self_test_fail <= 3'b010;
    dw(ADDR_CTL4, 8'h10);
    check({7'h0, self_check_done}, 8'h00);
    check({6'h0, system_clock_divider}, 8'h02);
    check({6'h0, framing_locked, sample_echo_enable}, 8'h00);
    dr(ADDR_CTL5, v);
    check(v, 8'h00);
    dr(ADDR_LSD0, v);
    check(v, 8'h33);
    repeat (STC + 5) @(posedge sys_clk);
    #1;
    check({7'h0, self_check_done}, 8'h01);
    dr(ADDR_CTL5, v);
    check(v, 8'h20);
    $display("software reset done");
    print_verdict();
  end
endmodule
